// ==== forwarder_assertions.sv ====
/*
  checker for the sensor bus register forwarder: status byte, read-back and bus idle.
  assumes it is bound to the forwarder top and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module forwarder_assertions #(
  parameter logic [23:0] SLOW_GAP = 24'h1_E848 // cycles between slow bytes
) (
  input wire logic i_clk, // clock
  input wire logic i_nrst, // async reset, active low
  input wire logic i_wr, // structure write strobe
  input wire logic [2:0] i_waddr, // write index
  input wire logic [7:0] i_wdata, // write data
  input wire logic [2:0] i_raddr, // read index
  input wire logic [7:0] o_rdata, // read data
  input wire logic i_start, // transfer trigger
  input wire logic [2:0] i_param, // parameter number
  input wire logic o_busy, // transfer running
  input wire logic i_scl, // scl level
  input wire logic i_sda, // sda level
  input wire logic o_scl_oe, // scl pull
  input wire logic o_sda_oe // sda pull
);
  logic started; // a transfer was ever accepted
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // ==========================================
  // helper: remembers the first accepted trigger
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      started <= 1'b0;
    else if (i_start && !o_busy && i_param inside {[3'h1:3'h6]})
      started <= 1'b1;
  end
  // ==========================================
  // properties
  AST_START_BUSY: assert property (
    i_start && !o_busy && i_param inside {[3'h1:3'h6]} |=> o_busy)
    else $error("accepted trigger did not raise busy");
  AST_BUSY_STATUS: assert property (
    o_busy && i_raddr == 3'h3 |=> o_rdata == 8'h00)
    else $error("status not zero while busy");
  AST_IDLE_STATUS: assert property (
    !started && i_raddr == 3'h3 |=> o_rdata == 8'h00)
    else $error("status not zero before any transfer");
  AST_DONE_STATUS: assert property (
    started && !o_busy && !i_start && i_raddr == 3'h3 |=> o_rdata inside {8'h01, 8'h02})
    else $error("finished status neither one nor two");
  AST_STATUS_HOLD: assert property (
    !o_busy && !i_start && i_raddr == 3'h3 ##1 !o_busy && !i_start && i_raddr == 3'h3
    |=> $stable(o_rdata))
    else $error("status moved while idle");
  AST_READBACK: assert property (
    !o_busy && i_wr && i_waddr == i_raddr && i_waddr inside {[3'h0:3'h2]}
    ##1 !i_wr && $stable(i_raddr) |=> o_rdata == $past(i_wdata, 2))
    else $error("structure byte did not read back");
  AST_IDLE_LINES: assert property (
    !o_busy && !$past(o_busy) |-> !o_scl_oe && !o_sda_oe)
    else $error("bus pulled while idle");
  AST_START_COND: assert property (
    $rose(o_busy) |-> ##[1:600] (o_sda_oe && !o_scl_oe))
    else $error("no start condition after trigger");
  // main scenarios reached
  cover property (started && !o_busy && $past(o_busy));
  cover property (i_wr && i_waddr == 3'h3 && !o_busy);
  cover property (o_busy && o_sda_oe && !o_scl_oe);
endmodule
`default_nettype wire

// ==== i2c_byte_master.v ====
/*
  i2c byte engine: start, optional repeated start, stop, one byte out or in.
  assumes open-drain pins resolved outside; scl and sda inputs pre-synchronised.
*/
`timescale 1ns/1ns
`default_nettype none
`include "passthru_map.vh"
module i2c_byte_master (
  input wire i_clk, // system clock
  input wire i_nrst, // async reset, active low
  input wire [2:0] i_cmd, // 1 start,2 stop,3 write,4 read
  input wire i_go, // one-cycle command pulse
  input wire [7:0] i_wdata, // byte to send
  input wire i_last, // read: answer nack
  output reg [7:0] o_rdata, // received byte
  output reg o_nack, // write saw no ack
  output reg o_done, // one-cycle done pulse
  output wire o_busy, // command running
  input wire i_scl, // synchronised scl level
  input wire i_sda, // synchronised sda level
  output reg o_scl_oe, // pull scl low
  output reg o_sda_oe // pull sda low
);
  // ==========================================================
  // sequencing: a bit is four quarter phases of PT_SCL_HALF_CYC plus one clocks each
  reg [7:0] cnt; // phase timer
  reg [1:0] ph; // quarter phase
  reg [3:0] bitn; // bit index, 8 is ack slot
  reg [2:0] cur; // running command
  reg [7:0] sh; // shift register
  assign o_busy = (cur != 3'h0);
  // engine; clock stretching honoured by holding while scl is held low
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt <= 8'h00;
      ph <= 2'h0;
      bitn <= 4'h0;
      cur <= 3'h0;
      sh <= 8'h00;
      o_rdata <= 8'h00;
      o_nack <= 1'b0;
      o_done <= 1'b0;
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (cur == 3'h0)
      begin
        if (i_go)
        begin
          cur <= i_cmd;
          sh <= i_wdata;
          o_nack <= 1'b0; // a stale nack must not fail the next start or stop
          ph <= 2'h0;
          bitn <= 4'h0;
          cnt <= 8'h00;
        end
      end
      else if (cnt != `PT_SCL_HALF_CYC)
        cnt <= cnt + 8'h01;
      else if (ph == 2'h2 && !o_scl_oe && !i_scl)
        cnt <= cnt; // slave stretching
      else
      begin
        cnt <= 8'h00;
        ph <= ph + 2'h1;
        case (cur)
          3'h1: // start or repeated start
            case (ph)
              2'h0: o_sda_oe <= 1'b0;
              2'h1: o_scl_oe <= 1'b0;
              2'h2: o_sda_oe <= 1'b1;
              default:
              begin
                o_scl_oe <= 1'b1;
                cur <= 3'h0;
                o_done <= 1'b1;
              end
            endcase
          3'h2: // stop
            case (ph)
              2'h0: o_sda_oe <= 1'b1;
              2'h1: o_scl_oe <= 1'b0;
              2'h2: o_sda_oe <= 1'b0;
              default:
              begin
                cur <= 3'h0;
                o_done <= 1'b1;
              end
            endcase
          default: // byte write or read, then ack slot
            case (ph)
              2'h0:
                if (bitn == 4'h8)
                  o_sda_oe <= (cur == 3'h4) ? !i_last : 1'b0;
                else
                  o_sda_oe <= (cur == 3'h3) ? !sh[7] : 1'b0;
              2'h1: o_scl_oe <= 1'b0;
              2'h2:
                if (bitn == 4'h8)
                  o_nack <= (cur == 3'h3) ? i_sda : 1'b0;
                else
                  sh <= {sh[6:0], i_sda};
              default:
              begin
                o_scl_oe <= 1'b1;
                if (bitn == 4'h8)
                begin
                  o_rdata <= sh;
                  cur <= 3'h0;
                  o_done <= 1'b1;
                end
                bitn <= bitn + 4'h1;
              end
            endcase
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== passthru_map.vh ====
/*
  constants for the sensor bus register forwarder: structure byte positions,
  parameter numbers, status codes and timing counts.
  assumes a 250 MHz system clock.
*/
`ifndef PASSTHRU_MAP_VH
`define PASSTHRU_MAP_VH
// ==========================================================
// structure byte positions
`define PT_BYTE_ADDR 3'h0
`define PT_BYTE_REG 3'h1
`define PT_BYTE_LEN 3'h2
`define PT_BYTE_STATUS 3'h3
`define PT_BYTE_DATA0 3'h4
// ==========================================================
// transfer parameter numbers and maximum length
`define PT_PARAM_RD_FAST 3'h1
`define PT_PARAM_WR_FAST 3'h2
`define PT_PARAM_RD_EMUL 3'h3
`define PT_PARAM_WR_EMUL 3'h4
`define PT_PARAM_RD_SLOW 3'h5
`define PT_PARAM_WR_SLOW 3'h6
`define PT_MAX_LEN 3'h4
// ==========================================================
// completion status codes
`define PT_ST_BUSY 8'h00
`define PT_ST_OK 8'h01
`define PT_ST_ERR 8'h02
// ==========================================================
// timing
`define PT_CLK_MHZ 250
`define PT_SLOW_GAP_NS 500000
// half a millisecond of clocks, sized to the 24-bit gap timer
`define PT_SLOW_GAP_CYC 24'h1_E848
`define PT_SCL_HALF_CYC 8'h7D
`endif

// ==== sensor_bus_register_forwarder.v ====
/*
  soft pass-through: host-side parameter structure and a sequencer that
  forwards register reads and writes onto the sensor i2c bus.
  assumes the host writes structure bytes one per cycle on the same clock and
  triggers a transfer with a parameter number; the bus has external pull-ups.
*/
// Overview of operation
// R1 - read structure: addr, reg, len, status, data
// R2 - write structure: addr, reg, len, status, data
// R3 - host reaches sensor registers during normal operation
// R4 - fast variants: one transaction, auto increment
// R5 - emulated variants: one transaction per byte
// R6 - slow variants add half millisecond gaps
// R7 - status zero while busy or never issued
// R8 - status one after clean finish
// R9 - status two on nack or error
// R10 - bytes one to three read back written
// R11 - host writes to status are discarded
// R12 - host polls status before next use
`timescale 1ns/1ns
`default_nettype none
`include "passthru_map.vh"
module sensor_bus_register_forwarder #(
  parameter [23:0] SLOW_GAP = `PT_SLOW_GAP_CYC // cycles between slow bytes
) (
  input wire i_clk, // 250 MHz clock
  input wire i_nrst, // async reset, active low
  input wire i_wr, // structure byte write strobe
  input wire [2:0] i_waddr, // structure byte index
  input wire [7:0] i_wdata, // structure byte data
  input wire [2:0] i_raddr, // structure byte read index
  output reg [7:0] o_rdata, // registered read data
  input wire i_start, // one-cycle transfer trigger
  input wire [2:0] i_param, // parameter number 1..6
  output wire o_busy, // transfer running
  input wire i_scl, // scl pin level
  input wire i_sda, // sda pin level
  output wire o_scl_oe, // drive scl low
  output wire o_sda_oe // drive sda low
);
  // ==========================================================
  // structure storage
  reg [7:0] tgt; // target address (7-bit, low bits)
  reg [7:0] sreg; // start register
  reg [7:0] slen; // length
  reg [7:0] status; // completion status
  reg [7:0] data [0:3]; // data bytes
  reg [1:0] scl_s; // pin synchroniser
  reg [1:0] sda_s; // pin synchroniser
  // states
  localparam [8:0] S_IDLE = 9'h001, S_START = 9'h002, S_ADW = 9'h004, S_REG = 9'h008,
    S_RST = 9'h010, S_ADR = 9'h020, S_DATA = 9'h040, S_STOP = 9'h080, S_GAP = 9'h100;
  reg [8:0] st; // sequencer state
  reg rd; // current transfer is a read
  reg single; // one byte per transaction
  reg slow; // gaps between bytes
  reg [2:0] idx; // byte index
  reg [2:0] cnt_len; // clamped length
  reg fail; // nack seen
  reg issued; // command pulse sent for this state
  reg [23:0] gap; // gap timer
  reg [2:0] cmd; // engine command
  reg go; // engine go pulse
  reg [7:0] wbyte; // engine write byte
  wire [7:0] eng_rdata; // engine read byte
  wire eng_nack; // engine nack
  wire eng_done; // engine done
  // length clamp to at most four bytes
  function [2:0] clamp_len;
    input [7:0] l;
    begin
      clamp_len = (l > 8'h04) ? `PT_MAX_LEN : l[2:0];
    end
  endfunction
  // true on the last byte of the current transaction
  function last_byte;
    input [2:0] i;
    input [2:0] n;
    input s;
    begin
      last_byte = s || (i + 3'h1 == n);
    end
  endfunction
  assign o_busy = (st != S_IDLE);
  // ==========================================================
  // pin synchronisers
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
    end
    else
    begin
      scl_s <= {scl_s[0], i_scl};
      sda_s <= {sda_s[0], i_sda};
    end
  end
  // ==========================================================
  // host read port
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_rdata <= 8'h00;
    else
      case (i_raddr)
        `PT_BYTE_ADDR: o_rdata <= tgt; // R1
        `PT_BYTE_REG: o_rdata <= sreg; // R10
        `PT_BYTE_LEN: o_rdata <= slen; // R10
        `PT_BYTE_STATUS: o_rdata <= status; // R7
        default: o_rdata <= data[i_raddr[1:0]]; // R1
      endcase
  end
  // ==========================================================
  // structure writes and the transfer sequencer
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tgt <= 8'h00;
      sreg <= 8'h00;
      slen <= 8'h00;
      status <= `PT_ST_BUSY; // R7
      data[0] <= 8'h00;
      data[1] <= 8'h00;
      data[2] <= 8'h00;
      data[3] <= 8'h00;
      st <= S_IDLE;
      rd <= 1'b0;
      single <= 1'b0;
      slow <= 1'b0;
      idx <= 3'h0;
      cnt_len <= 3'h0;
      fail <= 1'b0;
      issued <= 1'b0;
      gap <= 24'h00_0000;
      cmd <= 3'h0;
      go <= 1'b0;
      wbyte <= 8'h00;
    end
    else
    begin
      go <= 1'b0;
      // host writes land while idle; status byte is never writable
      if (i_wr && st == S_IDLE)
        case (i_waddr)
          `PT_BYTE_ADDR: tgt <= i_wdata; // R2
          `PT_BYTE_REG: sreg <= i_wdata; // R10
          `PT_BYTE_LEN: slen <= i_wdata; // R10
          `PT_BYTE_STATUS: ; // R11
          default: data[i_waddr[1:0]] <= i_wdata; // R2
        endcase
      // each state other than idle and gap issues one engine command then waits for done
      if (st != S_IDLE && st != S_GAP && !issued)
      begin
        issued <= 1'b1;
        go <= 1'b1;
        case (st)
          S_START, S_RST: cmd <= 3'h1;
          S_STOP: cmd <= 3'h2;
          S_ADW: wbyte <= {tgt[6:0], 1'b0};
          S_ADR: wbyte <= {tgt[6:0], 1'b1};
          S_REG: wbyte <= sreg + {5'h00, idx}; // R5
          default: wbyte <= data[idx[1:0]];
        endcase
        if (st == S_ADW || st == S_ADR || st == S_REG || (st == S_DATA && !rd))
          cmd <= 3'h3;
        if (st == S_DATA && rd)
          cmd <= 3'h4;
      end
      case (st)
        S_IDLE:
          if (i_start && i_param >= `PT_PARAM_RD_FAST && i_param <= `PT_PARAM_WR_SLOW)
          begin
            st <= S_START; // R3
            status <= `PT_ST_BUSY; // R7
            rd <= i_param[0];
            single <= (i_param >= `PT_PARAM_RD_EMUL); // R5
            slow <= (i_param >= `PT_PARAM_RD_SLOW); // R6
            idx <= 3'h0;
            cnt_len <= clamp_len(slen);
            fail <= 1'b0;
            issued <= 1'b0;
          end
        S_GAP:
          if (gap == 24'h00_0000)
          begin
            st <= S_START;
            issued <= 1'b0;
          end
          else
            gap <= gap - 24'h00_0001; // R6
        default:
          if (eng_done)
          begin
            issued <= 1'b0;
            if (eng_nack && st != S_DATA)
            begin
              fail <= 1'b1; // R9
              st <= S_STOP;
            end
            else
              case (st)
                S_START: st <= S_ADW;
                S_ADW: st <= S_REG;
                S_REG: st <= (cnt_len == 3'h0) ? S_STOP : (rd ? S_RST : S_DATA);
                S_RST: st <= S_ADR;
                S_ADR: st <= S_DATA;
                S_DATA:
                begin
                  if (rd)
                    data[idx[1:0]] <= eng_rdata;
                  if (!rd && eng_nack)
                  begin
                    fail <= 1'b1; // R9
                    st <= S_STOP;
                  end
                  else if (last_byte(idx, cnt_len, single))
                    st <= S_STOP;
                  idx <= idx + 3'h1; // R4
                end
                default: // stop finished
                  if (fail || idx >= cnt_len)
                  begin
                    st <= S_IDLE;
                    status <= fail ? `PT_ST_ERR : `PT_ST_OK; // R8
                  end
                  else
                  begin
                    st <= slow ? S_GAP : S_START; // R5
                    gap <= SLOW_GAP; // R6
                  end
              endcase
          end
      endcase
    end
  end
  // ==========================================================
  // bit-level engine; read ack is nack on the last byte of a transaction
  i2c_byte_master u_eng (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_cmd(cmd),
    .i_go(go),
    .i_wdata(wbyte),
    .i_last(last_byte(idx, cnt_len, single)),
    .o_rdata(eng_rdata),
    .o_nack(eng_nack),
    .o_done(eng_done),
    .o_busy(),
    .i_scl(scl_s[1]),
    .i_sda(sda_s[1]),
    .o_scl_oe(o_scl_oe),
    .o_sda_oe(o_sda_oe)
  );
endmodule
`default_nettype wire

// ==== sensor_bus_register_forwarder_bench.sv ====
/*
  bench for the sensor bus register forwarder with an i2c sensor model.
  assumes a 250 MHz clock and a short slow gap for run time.
*/
`timescale 1ns/1ns
`default_nettype none
module sensor_bus_register_forwarder_bench;
  localparam logic [23:0] GAP = 24'h0032; // shortened slow gap
  logic i_clk = 0, i_nrst = 0, i_wr = 0, i_start = 0; // driven inputs
  logic [2:0] i_waddr = 0, i_raddr = 0, i_param = 0; // indices
  logic [7:0] i_wdata = 0; // write data
  wire logic [7:0] o_rdata; // read data
  wire logic o_busy, o_scl_oe, o_sda_oe, s_oe; // outputs
  wire logic scl = !o_scl_oe; // pulled-up clock line
  wire logic sda = !(o_sda_oe | s_oe); // pulled-up data line
  int failures = 0, checked = 0, cyc[1:6];
  logic [31:0] seed = 32'h4ea9; // xorshift state
  logic [7:0] exp_q[$], rg, d[4]; // notes, register, data
  logic [2:0] idx_q[$]; // index notes
  logic rd_v = 0; // read note pending
  always #2 i_clk = ~i_clk;
  sensor_bus_register_forwarder #(.SLOW_GAP(GAP)) DUT (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_wr(i_wr), .i_waddr(i_waddr), .i_wdata(i_wdata), .i_raddr(i_raddr),
    .o_rdata(o_rdata), .i_start(i_start), .i_param(i_param), .o_busy(o_busy),
    .i_scl(scl), .i_sda(sda), .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe));
  sensor_model u_sens (.scl(scl), .sda(sda), .sda_oe(s_oe));
  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(negedge i_clk);
    i_wr = 1;
    i_waddr = a;
    i_raddr = a;
    i_wdata = v;
    @(negedge i_clk);
    i_wr = 0;
  endtask
  // read: note the expectation, the monitor compares
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(negedge i_clk);
    i_raddr = a;
    rd_v = 1;
    idx_q.push_back(a);
    exp_q.push_back(e);
    @(negedge i_clk);
    rd_v = 0;
  endtask
  task run(input logic [2:0] p, output int n);
    @(negedge i_clk);
    i_start = 1;
    i_param = p;
    @(negedge i_clk);
    i_start = 0;
    n = 0;
    rd(3'h3, 8'h00);
    while (o_busy !== 1'b0 && n < 60000)
    begin
      @(negedge i_clk);
      n++;
    end
    chk("busy", 8'h00, {7'h00, o_busy});
  endtask
  task summarize;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // monitor: oldest note against settled read data
  always @(posedge i_clk)
  begin
    #1;
    if (rd_v)
      chk($sformatf("byte%0d", idx_q.pop_front()), exp_q.pop_front(), o_rdata);
  end
  // watchdog well past the expected run
  initial
  begin
    #(4 * 250000);
    failures++;
    summarize;
  end
  // ==========================================
  // main sequence
  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      seed = xs(seed);
      u_sens.mem[i] = seed[7:0];
    end
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    i_nrst = 1;
    for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
    wr(3'h0, 8'h2a);
    wr(3'h1, 8'h37);
    wr(3'h2, 8'h04);
    wr(3'h3, 8'h55);
    rd(3'h1, 8'h37);
    rd(3'h2, 8'h04);
    rd(3'h3, 8'h00);
    for (int p = 1; p <= 6; p++)
    begin
      seed = xs(seed);
      rg = {1'b0, seed[6:0]};
      wr(3'h1, rg);
      wr(3'h2, (p % 2) ? 8'h02 : 8'h01);
      for (int i = 0; i < 4; i++)
      begin
        seed = xs(seed);
        d[i] = seed[7:0];
        wr(3'(4 + i), d[i]);
      end
      run(p[2:0], cyc[p]);
      rd(3'h3, 8'h01);
      for (int i = 0; i < ((p % 2) ? 2 : 1); i++)
        if (p % 2)
          rd(3'(4 + i), u_sens.mem[rg + i]);
        else
          chk("sensor reg", d[i], u_sens.mem[rg + i]);
    end
    checked++;
    if (cyc[5] < cyc[3] + GAP)
    begin
      failures++;
      $display("ERROR slow span exp %0d got %0d", cyc[3] + GAP, cyc[5]);
    end
    wr(3'h0, 8'h2b);
    run(3'h1, cyc[1]);
    rd(3'h3, 8'h02);
    wr(3'h3, 8'h01);
    rd(3'h3, 8'h02);
    // an out-of-range parameter number must leave the sequencer idle
    @(negedge i_clk);
    i_start = 1;
    i_param = 3'h7;
    @(negedge i_clk);
    i_start = 0;
    chk("busy", 8'h00, {7'h00, o_busy});
    rd(3'h3, 8'h02);
    summarize;
  end
endmodule
bind sensor_bus_register_forwarder forwarder_assertions #(.SLOW_GAP(SLOW_GAP)) u_chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_wr(i_wr), .i_waddr(i_waddr), .i_wdata(i_wdata),
  .i_raddr(i_raddr), .o_rdata(o_rdata), .i_start(i_start), .i_param(i_param),
  .o_busy(o_busy), .i_scl(i_scl), .i_sda(i_sda), .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe));
`default_nettype wire

// ==== sensor_model.sv ====
/*
  i2c sensor model: 256 registers with register advance per byte.
  assumes the bench resolves the pulled-up lines; it never stretches scl.
*/
`timescale 1ns/1ns
`default_nettype none
module sensor_model #(
  parameter logic [6:0] ADDR = 7'h2a // bus address answered
) (
  input wire logic scl, // bus clock level
  input wire logic sda, // bus data level
  output logic sda_oe // pull data low
);
  logic [7:0] mem [0:255]; // register file, filled by the bench
  logic [7:0] sh; // shifter; bit 7 is the next bit out
  logic [7:0] ptr; // register pointer
  int cnt; // clock count in the byte, 8 is the ack slot
  int ph; // 0 address, 1 register, 2 read data, 3 write data
  logic act; // addressed and listening
  logic rd; // read direction
  initial
  begin
    sda_oe = 0;
    act = 0;
    rd = 0;
    cnt = 0;
    ph = 0;
    ptr = 0;
    sh = 0;
  end
  // start or repeated start; the pointer survives it
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      act = 1;
      cnt = 0;
      ph = 0;
      rd = 0;
    end
  // stop frees the bus
  always @(posedge sda)
    if (scl === 1'b1)
    begin
      act = 0;
      sda_oe = 0;
    end
  // sample on rising clock; a master nack ends a read
  always @(posedge scl)
    if (act)
    begin
      if (cnt < 8)
        sh = {sh[6:0], sda};
      else if (ph == 2 && sda)
        act = 0;
      cnt = cnt + 1;
    end
  // drive on falling clock only, so no false start or stop
  always @(negedge scl)
    if (act)
    begin
      if (cnt == 8 && ph != 2)
      begin
        if (ph == 0)
        begin
          rd = sh[0];
          act = (sh[7:1] == ADDR);
          ph = rd ? 2 : 1;
        end
        else if (ph == 1)
        begin
          ptr = sh;
          ph = 3;
        end
        else
        begin
          mem[ptr] = sh;
          ptr = ptr + 8'h01;
        end
        sda_oe = act;
      end
      else if (cnt == 8)
        sda_oe = 0;
      else if (cnt == 9)
      begin
        cnt = 0;
        sda_oe = 0;
        if (ph == 2)
        begin
          sh = mem[ptr];
          ptr = ptr + 8'h01;
          sda_oe = !sh[7];
        end
      end
      else if (ph == 2 && cnt > 0)
        sda_oe = !sh[7];
    end
endmodule
`default_nettype wire
